// ==== src/eelus_pkg.sv ====
package eelus_pkg;

  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam int          BITS_W         = 8;
  localparam int          STAGE_N        = 3;
  localparam int          UV_CNT_W       = 20;

  // register offsets
  localparam logic [6:0]  OFF_MAIN_STATUS = 7'h03;
  localparam logic [6:0]  OFF_SYS_EN      = 7'h04;
  localparam logic [6:0]  OFF_GP_FIRST    = 7'h06;
  localparam logic [6:0]  OFF_GP_LAST     = 7'h09;
  localparam logic [6:0]  OFF_LOCK        = 7'h0A;
  localparam logic [6:0]  OFF_TRX_EN      = 7'h23;
  localparam logic [6:0]  OFF_WAKE_EN     = 7'h4C;
  localparam logic [6:0]  OFF_ID          = 7'h7E;

  // field positions
  localparam int          SYS_OTW_BIT    = 2;
  localparam int          SYS_SERIAL_FAIL_FLAG_BIT   = 1;
  localparam int          TRX_SIL_BIT    = 4;
  localparam int          TRX_FAIL_BIT   = 1;
  localparam int          TRX_WAKE_BIT   = 0;
  localparam int          WAKE_RISE_BIT  = 1;
  localparam int          WAKE_FALL_BIT  = 0;
  localparam int          FORCED_SLEEP_FLAG_BIT       = 7;

  // writable bits; everything else reads zero
  localparam logic [7:0]  SYS_EN_MASK    = 8'h06;
  localparam logic [7:0]  TRX_EN_MASK    = 8'h13;
  localparam logic [7:0]  WAKE_EN_MASK   = 8'h03;
  localparam logic [7:0]  LOCK_MASK      = 8'h7F;

  // reset values
  localparam logic [7:0]  SYS_EN_RST     = 8'h00;
  localparam logic [7:0]  TRX_EN_RST     = 8'h00;
  localparam logic [7:0]  WAKE_EN_RST    = 8'h00;
  localparam logic [7:0]  LOCK_RST       = 8'h00;
  localparam logic [7:0]  GP_RST         = 8'h00;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  // lock areas, index = lock bit
  localparam logic [6:0]  LOCK_LO [7] = '{7'h06, 7'h10, 7'h20, 7'h30,
                                          7'h40, 7'h50, 7'h68};
  localparam logic [6:0]  LOCK_HI [7] = '{7'h09, 7'h1F, 7'h2F, 7'h3F,
                                          7'h4F, 7'h5F, 7'h6F};

  // legal write frame lengths in bits
  localparam logic [7:0]  FRAME_BITS_2B  = 8'h10;
  localparam logic [7:0]  FRAME_BITS_3B  = 8'h18;
  localparam logic [7:0]  FRAME_BITS_4B  = 8'h20;

  // timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          UV_DELAY_NS    = 1000000;
  localparam int          UV_DELAY_CYC   =
    (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // identification code, value arbitrary
  localparam logic [7:0]  PART_ID_DEFAULT = 8'h5A;

  function automatic logic eelus_locked(input logic [6:0] addr,
                                        input logic [7:0] lock);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (lock[i] && addr >= LOCK_LO[i] && addr <= LOCK_HI[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : eelus_locked

endpackage : eelus_pkg

// ==== src/eelus_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - bit 2 of 0x04 enables overtemperature capture
// - bit 1 of 0x04 enables serial-fail detection
// - bit 4 of 0x23 enables bus-silence detection
// - bit 1 of 0x23 enables bus-failure capture
// - bit 0 of 0x23 enables bus wake-up
// - bit 1 of 0x4C enables wake rising edge
// - bit 0 of 0x4C enables wake falling edge
// - read-only variant id byte at 0x7E
// - lock bits at 0x0A block serial writes
// - bits 6,5,4 guard 68-6F, 50-5F, 40-4F
// - bits 3..0 guard 30-3F, 20-2F, 10-1F, 06-09
// - locks never block internal hardware updates
// - four user storage bytes at 0x06-0x09
// - lasting supply undervoltage forces sleep
// - clear captured events before forced sleep
// - forced sleep enables bus and wake-pin wake
// - forced sleep disables selective wake
// - selective_wake_disable pulses with event_clear_all
// - forced sleep sets flag, host restores settings
// - status bits clear on write one
// - bad-length write aborted, serial fail captured
module eelus_regs #(
  parameter logic [7:0]                     PART_ID =
    eelus_pkg::PART_ID_DEFAULT,
  parameter logic [eelus_pkg::UV_CNT_W-1:0] UV_DELAY_CYCLES =
    eelus_pkg::UV_CNT_W'(eelus_pkg::UV_DELAY_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wr_valid,
  input  wire logic [6:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        frame_end,
  input  wire logic        frame_write,
  input  wire logic [7:0]  frame_bits,
  input  wire logic [6:0]  rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        uv_core,
  input  wire logic        uv_interface,
  output logic             overtemp_warn_capture_en,
  output logic             serial_fail_capture_en,
  output logic             bus_silence_capture_en,
  output logic             bus_failure_capture_en,
  output logic             bus_wakeup_capture_en,
  output logic             wake_rise_capture_en,
  output logic             wake_fall_capture_en,
  output logic      [6:0]  write_lock,
  output logic             serial_fail_flag_set,
  output logic             event_clear_all,
  output logic             selective_wake_disable,
  output logic             force_sleep,
  output logic             forced_sleep_flag
);

  logic [7:0]  system_event_enable;
  logic [7:0]  transceiver_event_enable;
  logic [7:0]  wake_input_edge_enable;
  logic [7:0]  write_lock_control;
  logic [7:0]  user_storage_bytes [4];

  localparam int STAGE_LEN = eelus_pkg::STAGE_N;

  logic [6:0]  stage_addr [STAGE_LEN];
  logic [7:0]  stage_data [STAGE_LEN];
  logic [1:0]  stage_cnt;

  logic        len_ok;
  logic        commit;
  logic        bad_write;
  logic        uv_trip;
  logic        sleep_pending;

  eelus_uv_if uv_bus ();

  assign uv_bus.uv_core      = uv_core;
  assign uv_bus.uv_interface = uv_interface;
  assign uv_trip             = uv_bus.trip;

  eelus_uv_filter #(
    .DELAY_CYCLES (UV_DELAY_CYCLES)
  ) u_uv_filter (
    .clk  (clk),
    .rstn (rstn),
    .uv   (uv_bus.filter)
  );

  // bytes of a frame wait here until its length is known
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage_cnt <= 2'h0;
      for (int i = 0; i < STAGE_LEN; i++) begin
        stage_addr[i] <= 7'h00;
        stage_data[i] <= eelus_pkg::ZERO_BYTE;
      end
    end else if (frame_end) begin
      stage_cnt <= 2'h0;
    end else if (wr_valid && stage_cnt < 2'(STAGE_LEN)) begin
      stage_addr[stage_cnt] <= wr_addr;
      stage_data[stage_cnt] <= wr_data;
      stage_cnt             <= stage_cnt + 2'h1;
    end
  end

  assign len_ok = (frame_bits == eelus_pkg::FRAME_BITS_2B) ||
                  (frame_bits == eelus_pkg::FRAME_BITS_3B) ||
                  (frame_bits == eelus_pkg::FRAME_BITS_4B);
  assign commit    = frame_end && frame_write && len_ok;
  assign bad_write = frame_end && frame_write && !len_ok;

  // one staged byte lands on a register when unlocked
  function automatic logic hit(input int i, input logic [6:0] off);
    return commit && (2'(i) < stage_cnt) && (stage_addr[i] == off) &&
           !eelus_pkg::eelus_locked(off, write_lock_control);
  endfunction : hit

  // lock byte sits outside every area, so it is never self-locked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_lock_control <= eelus_pkg::LOCK_RST;
    end else begin
      for (int i = 0; i < STAGE_LEN; i++) begin
        if (hit(i, eelus_pkg::OFF_LOCK)) begin
          write_lock_control <= stage_data[i] & eelus_pkg::LOCK_MASK;
        end
      end
    end
  end

  // areas per lock bit: 6..4 then 3..0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_lock <= 7'h00;
    end else begin
      write_lock <= write_lock_control[6:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_event_enable <= eelus_pkg::SYS_EN_RST;
    end else begin
      for (int i = 0; i < STAGE_LEN; i++) begin
        if (hit(i, eelus_pkg::OFF_SYS_EN)) begin
          system_event_enable <=
            stage_data[i] & eelus_pkg::SYS_EN_MASK;
        end
      end
    end
  end

  // hardware sets after the loop win over a same-cycle write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transceiver_event_enable <= eelus_pkg::TRX_EN_RST;
    end else begin
      for (int i = 0; i < STAGE_LEN; i++) begin
        if (hit(i, eelus_pkg::OFF_TRX_EN)) begin
          transceiver_event_enable <=
            stage_data[i] & eelus_pkg::TRX_EN_MASK;
        end
      end
      if (uv_trip) begin
        transceiver_event_enable[eelus_pkg::TRX_WAKE_BIT] <=
          1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_input_edge_enable <= eelus_pkg::WAKE_EN_RST;
    end else begin
      for (int i = 0; i < STAGE_LEN; i++) begin
        if (hit(i, eelus_pkg::OFF_WAKE_EN)) begin
          wake_input_edge_enable <=
            stage_data[i] & eelus_pkg::WAKE_EN_MASK;
        end
      end
      if (uv_trip) begin
        wake_input_edge_enable[eelus_pkg::WAKE_RISE_BIT] <= 1'b1;
        wake_input_edge_enable[eelus_pkg::WAKE_FALL_BIT] <= 1'b1;
      end
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_user
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          user_storage_bytes[g] <= eelus_pkg::GP_RST;
        end else begin
          for (int i = 0; i < STAGE_LEN; i++) begin
            if (hit(i, eelus_pkg::OFF_GP_FIRST + 7'(g))) begin
              user_storage_bytes[g] <= stage_data[i];
            end
          end
        end
      end
    end
  endgenerate

  // enables go out through one flop from their register bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overtemp_warn_capture_en <= 1'b0;
    end else begin
      overtemp_warn_capture_en <=
        system_event_enable[eelus_pkg::SYS_OTW_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_fail_capture_en <= 1'b0;
    end else begin
      serial_fail_capture_en <=
        system_event_enable[eelus_pkg::SYS_SERIAL_FAIL_FLAG_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_silence_capture_en <= 1'b0;
    end else begin
      bus_silence_capture_en <=
        transceiver_event_enable[eelus_pkg::TRX_SIL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_failure_capture_en <= 1'b0;
    end else begin
      bus_failure_capture_en <=
        transceiver_event_enable[eelus_pkg::TRX_FAIL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_wakeup_capture_en <= 1'b0;
    end else begin
      bus_wakeup_capture_en <=
        transceiver_event_enable[eelus_pkg::TRX_WAKE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_rise_capture_en <= 1'b0;
    end else begin
      wake_rise_capture_en <=
        wake_input_edge_enable[eelus_pkg::WAKE_RISE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_fall_capture_en <= 1'b0;
    end else begin
      wake_fall_capture_en <=
        wake_input_edge_enable[eelus_pkg::WAKE_FALL_BIT];
    end
  end

  // aborted write: nothing commits, flag only when enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_fail_flag_set <= 1'b0;
    end else begin
      serial_fail_flag_set <= bad_write &&
        system_event_enable[eelus_pkg::SYS_SERIAL_FAIL_FLAG_BIT];
    end
  end

  // clear strobes first, sleep request one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_clear_all <= 1'b0;
    end else begin
      event_clear_all <= uv_trip;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selective_wake_disable <= 1'b0;
    end else begin
      selective_wake_disable <= uv_trip;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_pending <= 1'b0;
      force_sleep   <= 1'b0;
    end else begin
      sleep_pending <= uv_trip;
      force_sleep   <= sleep_pending;
    end
  end

  // write one clears; a trip in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      forced_sleep_flag <= 1'b0;
    end else if (uv_trip) begin
      forced_sleep_flag <= 1'b1;
    end else begin
      for (int i = 0; i < STAGE_LEN; i++) begin
        if (hit(i, eelus_pkg::OFF_MAIN_STATUS) &&
            stage_data[i][eelus_pkg::FORCED_SLEEP_FLAG_BIT]) begin
          forced_sleep_flag <= 1'b0;
        end
      end
    end
  end

  // unmapped and reserved bits read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= eelus_pkg::ZERO_BYTE;
    end else begin
      rd_data <= eelus_pkg::ZERO_BYTE;
      if (rd_addr == eelus_pkg::OFF_MAIN_STATUS) begin
        rd_data[eelus_pkg::FORCED_SLEEP_FLAG_BIT] <= forced_sleep_flag;
      end else if (rd_addr == eelus_pkg::OFF_SYS_EN) begin
        rd_data <= system_event_enable;
      end else if (rd_addr >= eelus_pkg::OFF_GP_FIRST &&
                   rd_addr <= eelus_pkg::OFF_GP_LAST) begin
        rd_data <= user_storage_bytes[2'(rd_addr -
                                         eelus_pkg::OFF_GP_FIRST)];
      end else if (rd_addr == eelus_pkg::OFF_LOCK) begin
        rd_data <= write_lock_control;
      end else if (rd_addr == eelus_pkg::OFF_TRX_EN) begin
        rd_data <= transceiver_event_enable;
      end else if (rd_addr == eelus_pkg::OFF_WAKE_EN) begin
        rd_data <= wake_input_edge_enable;
      end else if (rd_addr == eelus_pkg::OFF_ID) begin
        rd_data <= PART_ID;
      end
    end
  end

endmodule : eelus_regs

// ==== src/eelus_uv_filter.sv ====
`timescale 1ns/1ps
module eelus_uv_filter #(
  parameter logic [eelus_pkg::UV_CNT_W-1:0] DELAY_CYCLES =
    eelus_pkg::UV_CNT_W'(eelus_pkg::UV_DELAY_CYC)
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  eelus_uv_if.filter uv
);

  logic [1:0]                        sync_core;
  logic [1:0]                        sync_io;
  logic                              uv_any;
  logic                              armed;
  logic [eelus_pkg::UV_CNT_W-1:0]    cnt;

  // pins come from the analog side, two flops each
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_core <= 2'h0;
      sync_io   <= 2'h0;
    end else begin
      sync_core <= {sync_core[0], uv.uv_core};
      sync_io   <= {sync_io[0], uv.uv_interface};
    end
  end

  assign uv_any = sync_core[1] | sync_io[1];

  // trip only once the level has outlasted the delay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt   <= '0;
      armed <= 1'b1;
      uv.trip <= 1'b0;
    end else begin
      uv.trip <= 1'b0;
      if (!uv_any) begin
        cnt   <= '0;
        armed <= 1'b1;
      end else if (cnt < DELAY_CYCLES) begin
        cnt <= cnt + 1'b1;
      end else if (armed) begin
        uv.trip <= 1'b1;
        armed   <= 1'b0;
      end
    end
  end

endmodule : eelus_uv_filter

// ==== src/eelus_uv_if.sv ====
`timescale 1ns/1ps
interface eelus_uv_if;
  logic uv_core;
  logic uv_interface;
  logic trip;

  modport filter (
    input  uv_core,
    input  uv_interface,
    output trip
  );

  modport ctrl (
    output uv_core,
    output uv_interface,
    input  trip
  );
endinterface : eelus_uv_if

// ==== test/eelus_host.sv ====
`timescale 1ns/1ps
module eelus_host (
  input  wire logic       clk,
  output logic            wr_valid,
  output logic      [6:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            frame_end,
  output logic            frame_write,
  output logic      [7:0] frame_bits
);
  initial begin
    wr_valid = 1'b0;
    wr_addr = 7'h00;
    wr_data = 8'h00;
    frame_end = 1'b0;
    frame_write = 1'b0;
    frame_bits = 8'h00;
  end
  // n bytes after the address; bits given apart so bad lengths can be sent
  task automatic wr(input logic [6:0] a, input logic [7:0] d0, d1, d2,
                    input int n, input logic [7:0] bits);
    logic [7:0] d [3];
    d = '{d0, d1, d2};
    @(posedge clk) #1;
    for (int k = 0; k < n; k++) begin
      wr_valid = 1'b1;
      wr_addr = a + 7'(k);
      wr_data = d[k];
      @(posedge clk) #1;
    end
    wr_valid = 1'b0;
    // released lines must not keep the last byte
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
    frame_end = 1'b1;
    frame_write = 1'b1;
    frame_bits = bits;
    @(posedge clk) #1;
    frame_end = 1'b0;
    frame_write = 1'b0;
    frame_bits = ~bits;
  endtask : wr
endmodule : eelus_host

// ==== test/eelus_regs_sva.sv ====
`timescale 1ns/1ps
module eelus_regs_chk #(
  parameter logic [7:0]  PART_ID         = 8'h00,
  parameter logic [19:0] UV_DELAY_CYCLES = 20'h00008
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       frame_end,
  input wire logic       frame_write,
  input wire logic [7:0] frame_bits,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       uv_core,
  input wire logic       uv_interface,
  input wire logic       serial_fail_capture_en,
  input wire logic       bus_wakeup_capture_en,
  input wire logic       wake_rise_capture_en,
  input wire logic       wake_fall_capture_en,
  input wire logic       serial_fail_flag_set,
  input wire logic       event_clear_all,
  input wire logic       selective_wake_disable,
  input wire logic       force_sleep,
  input wire logic       forced_sleep_flag
);
  logic [1:0]  uv_sync;
  logic [19:0] uv_run;
  // mirrors the two-flop sync so the count lines up with the filter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uv_sync <= 2'h0;
      uv_run  <= 20'h00000;
    end else begin
      uv_sync <= {uv_sync[0], uv_core | uv_interface};
      uv_run  <= uv_sync[1] ? uv_run + 20'h00001 : 20'h00000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_bad_len_flag : assert property (
    frame_end && frame_write && serial_fail_capture_en &&
    !(frame_bits inside {8'h10, 8'h18, 8'h20}) |=> serial_fail_flag_set)
    else $error("serial fail pulse missing");
  chk_good_len_quiet : assert property (
    frame_end && frame_bits == 8'h10 |=> !serial_fail_flag_set)
    else $error("serial fail pulse on legal frame");
  chk_sleep_follows : assert property (
    event_clear_all |=> force_sleep && !event_clear_all)
    else $error("sleep not one cycle after event clear");
  chk_wake_restored : assert property (
    event_clear_all |-> forced_sleep_flag ##1 (bus_wakeup_capture_en &&
    wake_rise_capture_en && wake_fall_capture_en))
    else $error("wake enables or flag not set on trip");
  chk_sel_wake_off : assert property (
    selective_wake_disable == event_clear_all)
    else $error("selective wake disable not with trip");
  chk_uv_held : assert property (
    event_clear_all |-> uv_run >= UV_DELAY_CYCLES - 20'h00001)
    else $error("trip before undervoltage delay");
  chk_flag_cause : assert property (
    $rose(forced_sleep_flag) |-> event_clear_all)
    else $error("forced sleep flag without trip");
  chk_id_read : assert property (
    rd_addr == eelus_pkg::OFF_ID |=> rd_data == PART_ID)
    else $error("id byte wrong");
  chk_sys_rsvd : assert property (
    rd_addr == eelus_pkg::OFF_SYS_EN |=> (rd_data & 8'hF9) == 8'h00)
    else $error("reserved system enable bits not zero");
  cov_trip : cover property (event_clear_all);
  cov_fail : cover property (serial_fail_flag_set);
  cov_sleep : cover property (force_sleep);
endmodule : eelus_regs_chk

bind eelus_regs eelus_regs_chk #(.PART_ID(PART_ID),
  .UV_DELAY_CYCLES(UV_DELAY_CYCLES)) u_chk (.clk, .rstn, .frame_end,
  .frame_write, .frame_bits, .rd_addr, .rd_data, .uv_core, .uv_interface,
  .serial_fail_capture_en, .bus_wakeup_capture_en, .wake_rise_capture_en,
  .wake_fall_capture_en, .serial_fail_flag_set, .event_clear_all,
  .selective_wake_disable, .force_sleep, .forced_sleep_flag);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam logic [19:0] UVD = 20'h00008;
  localparam logic [7:0]  PID = 8'hA5; // arbitrary id value
  logic clk, rstn, uv_core, uv_interface, rq, rq_d;
  logic overtemp_warn_capture_en, serial_fail_capture_en;
  logic bus_silence_capture_en, bus_failure_capture_en;
  logic bus_wakeup_capture_en, wake_rise_capture_en, wake_fall_capture_en;
  logic serial_fail_flag_set, event_clear_all, selective_wake_disable;
  logic force_sleep, forced_sleep_flag, wr_valid, frame_end, frame_write;
  logic [6:0] wr_addr, rd_addr, write_lock;
  logic [7:0] wr_data, frame_bits, rd_data, v, lk, e06, e23, e4c;
  logic [31:0] g;
  int n_errors, n_compared, n_sf, n_ec, n_fs, n_sw;
  logic [7:0] exp_q [$];
  string nm_q [$];

  eelus_regs #(.PART_ID(PID), .UV_DELAY_CYCLES(UVD)) dut (.clk, .rstn,
    .wr_valid, .wr_addr, .wr_data, .frame_end, .frame_write, .frame_bits,
    .rd_addr, .rd_data, .uv_core, .uv_interface, .overtemp_warn_capture_en,
    .serial_fail_capture_en, .bus_silence_capture_en, .bus_failure_capture_en,
    .bus_wakeup_capture_en, .wake_rise_capture_en, .wake_fall_capture_en,
    .write_lock, .serial_fail_flag_set, .event_clear_all,
    .selective_wake_disable, .force_sleep, .forced_sleep_flag);
  eelus_host u_host (.clk, .wr_valid, .wr_addr, .wr_data, .frame_end,
    .frame_write, .frame_bits);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check_byte(string n, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check_byte

  task automatic check_cnt(string n, int e, int s);
    n_compared++;
    if (s != e) begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", n, e, s);
    end
  endtask : check_cnt

  task automatic rd(logic [6:0] a, logic [7:0] e, string n);
    @(posedge clk) #1;
    rd_addr = a;
    rq = 1'b1;
    exp_q.push_back(e);
    nm_q.push_back(n);
    @(posedge clk) #1;
    rq = 1'b0;
  endtask : rd

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // read data lands one edge after the address is taken
  always @(posedge clk) begin
    rq_d <= rq;
    if (rq_d) check_byte(nm_q.pop_front(), exp_q.pop_front(), rd_data);
    n_sf += serial_fail_flag_set;
    n_ec += event_clear_all;
    n_fs += force_sleep;
    n_sw += selective_wake_disable;
  end

  initial begin
    #80000;
    n_errors++;
    $display("ERROR watchdog expected done seen timeout");
    end_of_test();
  end

  initial begin
    {rstn, uv_core, uv_interface, rq} = 4'h0;
    rd_addr = 7'h00;
    void'($urandom(90));
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    rd(7'h04, 8'h00, "sys_en_rst");
    rd(7'h0A, 8'h00, "lock_rst");
    rd(7'h7E, PID, "id");
    u_host.wr(7'h04, 8'hFF, 8'h00, 8'h00, 1, 8'h10);
    u_host.wr(7'h23, 8'hFF, 8'h00, 8'h00, 1, 8'h10);
    u_host.wr(7'h4C, 8'hFF, 8'h00, 8'h00, 1, 8'h10);
    u_host.wr(7'h7E, 8'h00, 8'h00, 8'h00, 1, 8'h10);
    rd(7'h04, 8'h06, "sys_en");
    rd(7'h23, 8'h13, "trx_en");
    rd(7'h4C, 8'h03, "wake_en");
    rd(7'h7E, PID, "id_ro");
    v = {1'b0, overtemp_warn_capture_en, serial_fail_capture_en,
      bus_silence_capture_en, bus_failure_capture_en, bus_wakeup_capture_en,
      wake_rise_capture_en, wake_fall_capture_en};
    check_byte("enables", 8'h7F, v);
    g = $urandom;
    u_host.wr(7'h06, g[7:0], g[15:8], g[23:16], 3, 8'h20);
    for (int k = 0; k < 3; k++) rd(7'h06 + 7'(k), g[8*k+:8], "gp");
    u_host.wr(7'h04, 8'h00, 8'h00, 8'h00, 2, 8'h11);
    rd(7'h04, 8'h06, "bad_len");
    check_cnt("sf_pulses", 1, n_sf);
    u_host.wr(7'h04, 8'h04, 8'h00, 8'h00, 1, 8'h10);
    u_host.wr(7'h04, 8'h00, 8'h00, 8'h00, 2, 8'h28);
    rd(7'h04, 8'h04, "bad_len2");
    check_cnt("sf_gated", 1, n_sf);
    {e06, e23, e4c} = {g[7:0], 8'h13, 8'h03};
    for (int i = 0; i < 7; i++) begin
      v = 8'($urandom);
      lk = 8'h01 << i;
      u_host.wr(7'h0A, lk, 8'h00, 8'h00, 1, 8'h10);
      u_host.wr(7'h06, v, 8'h00, 8'h00, 1, 8'h10);
      u_host.wr(7'h23, v, 8'h00, 8'h00, 1, 8'h10);
      u_host.wr(7'h4C, v, 8'h00, 8'h00, 1, 8'h10);
      if (!lk[0]) e06 = v;
      if (!lk[2]) e23 = v & 8'h13;
      if (!lk[4]) e4c = v & 8'h03;
      rd(7'h06, e06, "gp_lock");
      rd(7'h23, e23, "trx_lock");
      rd(7'h4C, e4c, "wake_lock");
      check_byte("lock_out", lk, {1'b0, write_lock});
    end
    u_host.wr(7'h0A, 8'hFF, 8'h00, 8'h00, 1, 8'h10);
    rd(7'h0A, 8'h7F, "lock_rsvd");
    uv_core = 1'b1;
    repeat (5) @(posedge clk);
    #1 uv_core = 1'b0;
    repeat (12) @(posedge clk);
    check_cnt("short_uv", 0, n_ec);
    #1 uv_core = 1'b1;
    repeat (20) @(posedge clk);
    #1 uv_core = 1'b0;
    check_cnt("trips", 1, n_ec);
    check_cnt("sleeps", 1, n_fs);
    check_cnt("sel_wake", 1, n_sw);
    rd(7'h03, 8'h80, "fs_flag");
    rd(7'h23, e23 | 8'h01, "trx_locked_hw");
    rd(7'h4C, 8'h03, "wake_hw");
    u_host.wr(7'h03, 8'h00, 8'h00, 8'h00, 1, 8'h10);
    rd(7'h03, 8'h80, "fs_w0");
    u_host.wr(7'h03, 8'h80, 8'h00, 8'h00, 1, 8'h10);
    rd(7'h03, 8'h00, "fs_w1");
    uv_interface = 1'b1;
    repeat (20) @(posedge clk);
    #1 uv_interface = 1'b0;
    check_cnt("trips_io", 2, n_ec);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule : testbench
